// ### hdl/byte_bit_op_execute.sv
// Execute stage for add, AND, bit set/clear, bit test-and-skip and direction load.
//
// Summary of operation
// - Program counter writes, except unconditional branch, force counter bit 8 low.
// - Rewriting an I/O port uses sampled pin levels as the source value.
// - Direction load with operand 6 copies accumulator into second port direction.
// - Direction bit one tri-states its pin; zero enables the driver.
// - Marked file writes to the timer register clear prescaler when assigned.
// - Add sums accumulator and file, destination bit picks target, sets C, DC, Z.
// - File address is five bits, 0 to 31; bit number three bits, 0 to 7.
// - Bit clear zeroes one bit, keeps others and all flags.
// - Bit set ones one bit, keeps others and all flags.
// - AND literal masks accumulator with eight-bit literal, only zero flag changes.
// - AND file masks accumulator with file, destination bit picks target, zero flag.
// - Skip-if-clear skips next instruction when bit reads zero, no flag change.
// - Skip-if-set skips next instruction when bit reads one, no flag change.
// - A taken skip discards prefetched word and runs a no-operation instead.
// - Instruction cycle is four clocks; skips or counter changes take two.
`timescale 1ns/10ps
module byte_bit_op_execute #(
	parameter int FILE_DEPTH = 32
) (
	input  wire logic                              clk,
	input  wire logic                              nrst,
	input  wire logic [bitop_pkg::OPCODE_WIDTH-1:0] opcode,
	input  wire logic                              prescalerOnTimer,
	input  wire logic                        [7:0] portPinIn,
	output logic                             [7:0] portPinOut,
	output logic                             [7:0] portPinOe,
	output logic                             [7:0] accumulator,
	output logic                                   carryFlag,
	output logic                                   digitCarryFlag,
	output logic                                   zeroFlag,
	output logic                                   skipNext,
	output logic                                   prescalerClear,
	output logic                                   programCounterWrite,
	output logic                             [8:0] programCounterLow,
	output logic                                   cycleStart
);
	import bitop_pkg::*;

	// Refused at elaboration: the address field is fixed at five bits.
	if (FILE_DEPTH != 32) begin : g_bad_depth
		$error("file depth must be 32 to match the five-bit address field");
	end

	// ****************************************************************
	// Instruction cycle timing
	// ****************************************************************
	logic [1:0] phase;
	logic       cycleEnd;

	cycle_phase #(
		.PERIODS (OSC_PER_CYCLE)
	) u_phase (
		.clk      (clk),
		.nrst     (nrst),
		.phase    (phase),
		.cycleEnd (cycleEnd)
	);

	// Pins come from outside the clock domain, so two flops first.
	logic [7:0] pinMeta;
	logic [7:0] pinSync;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pinMeta <= 8'h00;
			pinSync <= 8'h00;
		end else begin
			pinMeta <= portPinIn;
			pinSync <= pinMeta;
		end
	end

	// ****************************************************************
	// Decode
	// ****************************************************************
	logic [4:0]  fileAddr;
	logic [2:0]  bitNum;
	logic        destFile;
	logic [7:0]  literal;
	exec_state_type state;
	logic [11:0] execWord;
	logic isAdd, isAndF, isMove, isBcf, isBsf, isSkc, isSks, isAndL, isBranch, isDir;

	// A flushed slot runs as a no-operation in place of the prefetched word.
	assign execWord = (state == EXEC_FLUSH) ? OPC_NO_OPERATION : opcode;
	assign fileAddr = execWord[FILE_ADDR_LSB +: FILE_ADDR_BITS];
	assign bitNum   = execWord[BIT_NUM_LSB +: BIT_NUM_BITS];
	assign destFile = execWord[DEST_BIT_POS];
	assign literal  = execWord[LITERAL_BITS-1:0];
	assign isAdd    = (execWord[11:6] == OPC_ADD_ACC_FILE);
	assign isAndF   = (execWord[11:6] == OPC_AND_ACC_FILE);
	assign isMove   = (execWord[11:6] == OPC_MOVE_FILE);
	assign isBcf    = (execWord[11:8] == OPC_BIT_CLEAR);
	assign isBsf    = (execWord[11:8] == OPC_BIT_SET);
	assign isSkc    = (execWord[11:8] == OPC_SKIP_IF_CLEAR);
	assign isSks    = (execWord[11:8] == OPC_SKIP_IF_SET);
	assign isAndL   = (execWord[11:8] == OPC_AND_ACC_LITERAL);
	assign isBranch = (execWord[11:9] == OPC_UNCOND_BRANCH);
	assign isDir    = (execWord[11:3] == OPC_DIRECTION_LOAD) && (execWord[2:0] != 3'h0);

	// ****************************************************************
	// Operand read and ALU
	// ****************************************************************
	logic [7:0] fileMem [FILE_DEPTH];
	logic [7:0] portLatch;
	logic [7:0] direction;
	logic [7:0] operand;
	logic [8:0] sum;
	logic [4:0] lowSum;
	logic [7:0] result;
	logic [7:0] bitMask;
	logic       writeFile;
	logic       writeAcc;
	logic       testBit;
	logic       skipTaken;

	// Port reads return pin levels, never the latch contents.
	always_comb begin
		if (fileAddr == ADDR_SECOND_PORT) begin
			operand = pinSync;
		end else begin
			operand = fileMem[fileAddr];
		end
	end

	assign sum     = {1'b0, accumulator} + {1'b0, operand};
	assign lowSum  = {1'b0, accumulator[3:0]} + {1'b0, operand[3:0]};
	assign bitMask = 8'h01 << bitNum;
	assign testBit = operand[bitNum];

	// Result selection for every supported operation.
	always_comb begin
		result = operand;
		if (isAdd) begin
			result = sum[7:0];
		end else if (isAndF) begin
			result = accumulator & operand;
		end else if (isAndL) begin
			result = accumulator & literal;
		end else if (isBcf) begin
			result = operand & ~bitMask;
		end else if (isBsf) begin
			result = operand | bitMask;
		end
	end

	assign writeFile = ((isAdd || isAndF || isMove) && destFile) || isBcf || isBsf;
	assign writeAcc  = ((isAdd || isAndF || isMove) && !destFile) || isAndL;
	assign skipTaken = (isSkc && !testBit) || (isSks && testBit);

	// ****************************************************************
	// Skip sequencing
	// ****************************************************************
	// A taken skip or a counter change flushes the next slot.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= EXEC_NORMAL;
		end else if (cycleEnd) begin
			case (state)
				EXEC_NORMAL: begin
					if (skipTaken || isBranch ||
					    (writeFile && fileAddr == ADDR_PROG_COUNTER)) begin
						state <= EXEC_FLUSH;
					end
				end
				EXEC_FLUSH: begin
					state <= EXEC_NORMAL;
				end
				default: begin
					state <= EXEC_NORMAL;
				end
			endcase
		end
	end

	assign skipNext   = (state == EXEC_FLUSH);
	assign cycleStart = (phase == 2'h0);

	// ****************************************************************
	// Accumulator and flags
	// ****************************************************************
	// Bit operations and tests leave every flag alone.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			accumulator    <= ACC_RESET;
			carryFlag      <= 1'b0;
			digitCarryFlag <= 1'b0;
			zeroFlag       <= 1'b0;
		end else if (cycleEnd) begin
			if (writeAcc) begin
				accumulator <= result;
			end
			if (isAdd) begin
				carryFlag      <= sum[8];
				digitCarryFlag <= lowSum[4];
			end
			if (isAdd || isAndF || isAndL || isMove) begin
				zeroFlag <= (result == 8'h00);
			end
		end
	end

	// ****************************************************************
	// File registers, port latch and direction
	// ****************************************************************
	// Full-byte writeback: a bit set/clear changes one bit, the rest taken from the pins.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			portLatch <= LATCH_RESET;
		end else if (cycleEnd && writeFile && fileAddr == ADDR_SECOND_PORT) begin
			portLatch <= result;
		end
	end

	always_ff @(posedge clk) begin
		if (cycleEnd && writeFile && fileAddr != ADDR_SECOND_PORT) begin
			fileMem[fileAddr] <= result;
		end
	end

	// Direction latch loads from the accumulator only for the second port.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			direction <= DIRECTION_RESET;
		end else if (cycleEnd && isDir && execWord[2:0] == DIRECTION_PORT_SEL) begin
			direction <= accumulator;
		end
	end

	assign portPinOut = portLatch;
	assign portPinOe  = ~direction;

	// ****************************************************************
	// Side effects on timer and program counter
	// ****************************************************************
	logic [8:0] pcLow;
	logic       pcWrite;
	logic       preClr;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pcLow   <= 9'h000;
			pcWrite <= 1'b0;
			preClr  <= 1'b0;
		end else if (cycleEnd) begin
			preClr  <= writeFile && fileAddr == ADDR_TIMER_COUNT && prescalerOnTimer;
			pcWrite <= writeFile && fileAddr == ADDR_PROG_COUNTER;
			if (writeFile && fileAddr == ADDR_PROG_COUNTER) begin
				pcLow <= {1'b0, result};
			end
		end else begin
			preClr  <= 1'b0;
			pcWrite <= 1'b0;
		end
	end

	assign prescalerClear      = preClr;
	assign programCounterWrite = pcWrite;
	assign programCounterLow   = pcLow;

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_pc_bit8;
		@(posedge clk) disable iff (!nrst) programCounterWrite |-> !programCounterLow[PC_BIT_FORCED];
	endproperty
	a_pc_bit8: assert property (p_pc_bit8) else $error("counter bit 8 not forced low");

	property p_dir_oe;
		@(posedge clk) disable iff (!nrst)
			(cycleEnd && isDir && execWord[2:0] == DIRECTION_PORT_SEL) |=> (portPinOe == ~$past(accumulator));
	endproperty
	a_dir_oe: assert property (p_dir_oe) else $error("direction load mismatch");

	property p_skip_two;
		@(posedge clk) disable iff (!nrst)
			(cycleEnd && state == EXEC_NORMAL && skipTaken) |=> skipNext [*4] ##1 !skipNext;
	endproperty
	a_skip_two: assert property (p_skip_two) else $error("skip slot not one cycle");

	property p_bit_flags;
		@(posedge clk) disable iff (!nrst)
			(cycleEnd && (isBcf || isBsf || isSkc || isSks)) |=> $stable(zeroFlag) && $stable(carryFlag);
	endproperty
	a_bit_flags: assert property (p_bit_flags) else $error("bit op changed flags");

	property p_add_carry;
		@(posedge clk) disable iff (!nrst) (cycleEnd && isAdd) |=> carryFlag == $past(sum[8]);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("carry wrong after add");

	property p_andl;
		@(posedge clk) disable iff (!nrst)
			(cycleEnd && isAndL) |=> accumulator == ($past(accumulator) & $past(literal));
	endproperty
	a_andl: assert property (p_andl) else $error("literal AND wrong");

	property p_zero;
		@(posedge clk) disable iff (!nrst) (cycleEnd && isAndF) |=> zeroFlag == ($past(result) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_prescaler;
		@(posedge clk) disable iff (!nrst)
			(cycleEnd && writeFile && fileAddr == ADDR_TIMER_COUNT && prescalerOnTimer) |=> prescalerClear;
	endproperty
	a_prescaler: assert property (p_prescaler) else $error("prescaler not cleared");

	property p_cycle;
		@(posedge clk) disable iff (!nrst) cycleEnd |=> !cycleEnd [*3] ##1 cycleEnd;
	endproperty
	a_cycle: assert property (p_cycle) else $error("cycle not four clocks");

	c_skip: cover property (@(posedge clk) disable iff (!nrst) cycleEnd && skipTaken);
	c_port: cover property (@(posedge clk) disable iff (!nrst) cycleEnd && isBsf && fileAddr == ADDR_SECOND_PORT);
	c_dir:  cover property (@(posedge clk) disable iff (!nrst) cycleEnd && isDir);
endmodule

// ### inc/bitop_pkg.sv
// Package with opcode fields, file addresses, reset values and timing for the execute block.
package bitop_pkg;
	// ****************************************************************
	// Instruction word layout
	// ****************************************************************
	localparam int  OPCODE_WIDTH   = 12;
	localparam int  FILE_ADDR_LSB  = 0;
	localparam int  FILE_ADDR_BITS = 5;
	localparam int  DEST_BIT_POS   = 5;
	localparam int  BIT_NUM_LSB    = 5;
	localparam int  BIT_NUM_BITS   = 3;
	localparam int  LITERAL_BITS   = 8;

	// ****************************************************************
	// Opcode patterns (upper bits of the word)
	// ****************************************************************
	localparam logic [5:0] OPC_ADD_ACC_FILE      = 6'h07;
	localparam logic [5:0] OPC_AND_ACC_FILE      = 6'h05;
	localparam logic [5:0] OPC_MOVE_FILE         = 6'h08;
	localparam logic [3:0] OPC_BIT_CLEAR         = 4'h4;
	localparam logic [3:0] OPC_BIT_SET           = 4'h5;
	localparam logic [3:0] OPC_SKIP_IF_CLEAR     = 4'h6;
	localparam logic [3:0] OPC_SKIP_IF_SET       = 4'h7;
	localparam logic [3:0] OPC_AND_ACC_LITERAL   = 4'he;
	localparam logic [2:0] OPC_UNCOND_BRANCH     = 3'h5;
	localparam logic [8:0] OPC_DIRECTION_LOAD    = 9'h000;
	localparam logic [11:0] OPC_NO_OPERATION     = 12'h000;

	// ****************************************************************
	// File addresses with side effects
	// ****************************************************************
	localparam logic [4:0] ADDR_TIMER_COUNT  = 5'h01;
	localparam logic [4:0] ADDR_PROG_COUNTER = 5'h02;
	localparam logic [4:0] ADDR_SECOND_PORT  = 5'h06;
	localparam logic [2:0] DIRECTION_PORT_SEL = 3'h6;

	// ****************************************************************
	// Reset values and timing
	// ****************************************************************
	localparam logic [7:0] ACC_RESET       = 8'h00;
	localparam logic [7:0] DIRECTION_RESET = 8'hff;
	localparam logic [7:0] LATCH_RESET     = 8'h00;
	localparam logic [7:0] FILE_RESET      = 8'h00;
	localparam int  OSC_PER_CYCLE  = 4;
	localparam int  PHASE_BITS     = 2;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam int  PC_BIT_FORCED  = 8;

	typedef enum logic [1:0] {
		EXEC_NORMAL = 2'b00,
		EXEC_FLUSH  = 2'b01
	} exec_state_type;
endpackage

// ### hdl/cycle_phase.sv
// Divider that splits the oscillator clock into four-period instruction cycles.
`timescale 1ns/10ps
module cycle_phase #(
	parameter int PERIODS = bitop_pkg::OSC_PER_CYCLE
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	output logic      [1:0] phase,
	output logic            cycleEnd
);
	import bitop_pkg::*;

	// Refused at elaboration: the phase counter is two bits and wraps on its own.
	if (PERIODS != 4) begin : g_bad_periods
		$error("cycle_phase supports exactly four periods per cycle");
	end

	// ****************************************************************
	// Phase counter
	// ****************************************************************
	// Free-running count; the last phase marks the end of a cycle.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	assign cycleEnd = (phase == PHASE_LAST);
endmodule

// ### verif/tb_byte_bit_op_execute.sv
// Self-checking testbench for the byte and bit operation execute block.
`timescale 1ns/10ps
`define CHK(act, exp) \
	begin \
		compares++; \
		if ((act) !== (exp)) begin \
			nFail++; \
			$display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp); \
		end \
	end
module tb_byte_bit_op_execute;
	import bitop_pkg::*;
	logic        clk;
	logic        nrst;
	logic [11:0] opcode;
	logic        prescalerOnTimer;
	logic [7:0]  portPinIn;
	logic [7:0]  portPinOut;
	logic [7:0]  portPinOe;
	logic [7:0]  accumulator;
	logic        carryFlag;
	logic        digitCarryFlag;
	logic        zeroFlag;
	logic        skipNext;
	logic        prescalerClear;
	logic        programCounterWrite;
	logic [8:0]  programCounterLow;
	logic        cycleStart;
	int          nFail;
	int          compares;
	int          nClr;
	int          nPcw;
	int          skipCnt;
	logic [8:0]  pcSeen;

	byte_bit_op_execute i_dut (
		.clk                 (clk),
		.nrst                (nrst),
		.opcode              (opcode),
		.prescalerOnTimer    (prescalerOnTimer),
		.portPinIn           (portPinIn),
		.portPinOut          (portPinOut),
		.portPinOe           (portPinOe),
		.accumulator         (accumulator),
		.carryFlag           (carryFlag),
		.digitCarryFlag      (digitCarryFlag),
		.zeroFlag            (zeroFlag),
		.skipNext            (skipNext),
		.prescalerClear      (prescalerClear),
		.programCounterWrite (programCounterWrite),
		.programCounterLow   (programCounterLow),
		.cycleStart          (cycleStart)
	);

	// Free-running 25 MHz clock.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Count one-clock pulses at the falling edge, where they are settled.
	always @(negedge clk) begin
		if (prescalerClear === 1'b1) nClr++;
		if (programCounterWrite === 1'b1) begin
			nPcw++;
			pcSeen = programCounterLow;
		end
	end

	// ****************************************************************
	// Opcode builders and bus tasks
	// ****************************************************************
	function automatic logic [11:0] fop(input logic [5:0] o, input logic d, input logic [4:0] f);
		return {o, d, f};
	endfunction
	function automatic logic [11:0] bop(input logic [3:0] o, input logic [2:0] b, input logic [4:0] f);
		return {o, b, f};
	endfunction

	// Closing report; also the exit for an exhausted wait.
	task automatic printVerdict();
		$display("Comparisons %0d, mismatches %0d", compares, nFail);
		if (nFail == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// One instruction slot: align to phase 0, hold the word for four clocks, count flushed clocks.
	task automatic exec(input logic [11:0] op);
		int n;
		n = 0;
		while (cycleStart !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		if (n == 8) begin
			nFail++;
			printVerdict();
		end
		opcode = op;
		skipCnt = 0;
		for (int i = 0; i < 4; i++) begin
			if (skipNext === 1'b1) skipCnt++;
			@(negedge clk);
		end
		`CHK(cycleStart, 1'b1)
	endtask

	// File registers have no reset, so a value is built one bit at a time.
	task automatic setf(input logic [4:0] f, input logic [7:0] v);
		for (int b = 0; b < 8; b++) begin
			exec(bop(v[b] ? OPC_BIT_SET : OPC_BIT_CLEAR, 3'(b), f));
		end
	endtask

	task automatic flags(input logic c, input logic dc, input logic z);
		`CHK({carryFlag, digitCarryFlag, zeroFlag}, {c, dc, z})
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic testArith();
		setf(5'd10, 8'h8f);
		setf(5'd11, 8'he1);
		exec(fop(OPC_ADD_ACC_FILE, 1'b0, 5'd10));
		`CHK(accumulator, 8'h8f)
		flags(1'b0, 1'b0, 1'b0);
		exec(fop(OPC_ADD_ACC_FILE, 1'b1, 5'd10));
		`CHK(accumulator, 8'h8f)
		flags(1'b1, 1'b1, 1'b0);
		exec(fop(OPC_AND_ACC_FILE, 1'b0, 5'd11));
		`CHK(accumulator, 8'h81)
		flags(1'b1, 1'b1, 1'b0);
		exec({OPC_AND_ACC_LITERAL, 8'h00});
		`CHK(accumulator, 8'h00)
		flags(1'b1, 1'b1, 1'b1);
		exec(fop(OPC_MOVE_FILE, 1'b0, 5'd10));
		`CHK(accumulator, 8'h1e)
		exec(fop(OPC_AND_ACC_FILE, 1'b1, 5'd11));
		`CHK(zeroFlag, 1'b1)
		exec(fop(OPC_MOVE_FILE, 1'b0, 5'd11));
		`CHK(accumulator, 8'h00)
		exec(fop(OPC_ADD_ACC_FILE, 1'b0, 5'd10));
		flags(1'b0, 1'b0, 1'b0);
		exec({OPC_AND_ACC_LITERAL, 8'hff});
		`CHK(accumulator, 8'h1e)
		// Highest file address, with the zero flag set so untouched flags show.
		exec({OPC_AND_ACC_LITERAL, 8'h00});
		setf(5'd31, 8'ha5);
		flags(1'b0, 1'b0, 1'b1);
		exec(fop(OPC_MOVE_FILE, 1'b0, 5'd31));
		`CHK(accumulator, 8'ha5)
	endtask

	// Test a bit of file 10 (holding 1e); a taken skip must swallow the following literal AND.
	task automatic skipCase(input logic [3:0] o, input logic [2:0] b, input logic taken);
		exec(bop(o, b, 5'd10));
		exec({OPC_AND_ACC_LITERAL, taken ? 8'h00 : 8'hff});
		`CHK(skipCnt, taken ? 4 : 0)
		`CHK(accumulator, 8'ha5)
		flags(1'b0, 1'b0, 1'b0);
	endtask

	task automatic testPort();
		portPinIn = 8'h3c;
		setf(5'd12, 8'hf0);
		exec(fop(OPC_MOVE_FILE, 1'b0, 5'd12));
		exec({OPC_DIRECTION_LOAD, 3'h6});
		`CHK(portPinOe, 8'h0f)
		exec({OPC_AND_ACC_LITERAL, 8'h30});
		exec({OPC_DIRECTION_LOAD, 3'h5});
		`CHK(portPinOe, 8'h0f)
		exec(bop(OPC_BIT_SET, 3'd0, ADDR_SECOND_PORT));
		`CHK(portPinOut, 8'h3d)
		portPinIn = 8'hff;
		exec(OPC_NO_OPERATION);
		exec(bop(OPC_BIT_CLEAR, 3'd2, ADDR_SECOND_PORT));
		`CHK(portPinOut, 8'hfb)
	endtask

	// A file operation on the timer register and the expected number of prescaler clears.
	task automatic tmrCase(input logic [11:0] op, input logic on, input int inc);
		int c0;
		c0 = nClr;
		prescalerOnTimer = on;
		exec(op);
		exec(OPC_NO_OPERATION);
		`CHK(nClr - c0, inc)
	endtask

	task automatic pcCase(input logic [11:0] op);
		int c0;
		c0 = nPcw;
		exec(op);
		exec(OPC_NO_OPERATION);
		`CHK(nPcw - c0, 1)
		`CHK(pcSeen[8], 1'b0)
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		nrst = 1'b0;
		opcode = OPC_NO_OPERATION;
		prescalerOnTimer = 1'b0;
		portPinIn = 8'h00;
		nFail = 0;
		compares = 0;
		nClr = 0;
		nPcw = 0;
		repeat (16) @(negedge clk);
		nrst = 1'b1;
		`CHK({accumulator, portPinOut, portPinOe}, {ACC_RESET, LATCH_RESET, ~DIRECTION_RESET})
		`CHK({carryFlag, digitCarryFlag, zeroFlag, skipNext}, 4'h0)
		testArith();
		skipCase(OPC_SKIP_IF_CLEAR, 3'd0, 1'b1);
		skipCase(OPC_SKIP_IF_CLEAR, 3'd1, 1'b0);
		skipCase(OPC_SKIP_IF_SET, 3'd4, 1'b1);
		skipCase(OPC_SKIP_IF_SET, 3'd7, 1'b0);
		testPort();
		// The timer file has no reset; give it a value before the adds read it.
		setf(ADDR_TIMER_COUNT, 8'h00);
		tmrCase(bop(OPC_BIT_SET, 3'd0, ADDR_TIMER_COUNT), 1'b1, 1);
		tmrCase(fop(OPC_ADD_ACC_FILE, 1'b0, ADDR_TIMER_COUNT), 1'b1, 0);
		tmrCase(fop(OPC_ADD_ACC_FILE, 1'b1, ADDR_TIMER_COUNT), 1'b1, 1);
		tmrCase(bop(OPC_BIT_CLEAR, 3'd0, ADDR_TIMER_COUNT), 1'b0, 0);
		// The counter file has no reset either; an AND with a zero accumulator defines it.
		exec({OPC_AND_ACC_LITERAL, 8'h00});
		pcCase(fop(OPC_AND_ACC_FILE, 1'b1, ADDR_PROG_COUNTER));
		`CHK(pcSeen, 9'h000)
		pcCase(bop(OPC_BIT_SET, 3'd3, ADDR_PROG_COUNTER));
		`CHK(pcSeen, 9'h008)
		pcCase(fop(OPC_ADD_ACC_FILE, 1'b1, ADDR_PROG_COUNTER));
		`CHK(pcSeen, 9'h008)
		printVerdict();
	end
endmodule
